// *** rtl/cge_pkg.sv ***
package cge_pkg;
   // register offsets
   localparam logic [7:0] ADDR_IDENT = 8'h00;
   localparam logic [7:0] ADDR_FACTORY_ONE = 8'h01;
   localparam logic [7:0] ADDR_POWER_SIG = 8'h02;
   localparam logic [7:0] ADDR_ENABLE_MODE = 8'h03;
   localparam logic [7:0] ADDR_RESERVED_FOUR = 8'h04;
   // power-on values
   localparam logic [7:0] RST_FACTORY_ONE = 8'hA7;
   localparam logic [7:0] RST_POWER_SIG = 8'h50;
   localparam logic [7:0] RST_ENABLE_MODE = 8'hE9;
   localparam logic [7:0] RST_RESERVED_FOUR = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // field positions
   localparam int SLEEP_BIT = 7;
   localparam int SIG_DISABLE_BIT = 1;
   localparam int CTRL_HI = 7;
   localparam int CTRL_LO = 6;
   localparam int PULSE_HI = 5;
   localparam int PULSE_LO = 3;
   localparam int MODE_HI = 2;
   localparam int MODE_LO = 0;
   localparam int VERSION_LO = 4;
   // limit switch output control codes
   localparam logic [1:0] CTRL_ASSERT = 2'h0;
   localparam logic [1:0] CTRL_FACTORY = 2'h1;
   localparam logic [1:0] CTRL_DEASSERT = 2'h2;
   localparam logic [1:0] CTRL_BY_MODE = 2'h3;
   // operating modes
   localparam logic [2:0] autodetect_2a_mode = 3'h0;
   localparam logic [2:0] pass_through_mode = 3'h1;
   localparam logic [2:0] shorted_charger_mode = 3'h2;
   localparam logic [2:0] downstream_port_emulation_mode = 3'h3;
   localparam logic [2:0] autodetect_1a_mode = 3'h4;
   localparam logic [2:0] forced_1a_divider_mode = 3'h5;
   localparam logic [2:0] forced_2a_divider_mode = 3'h6;
   localparam logic [2:0] FORCED_TABLET_MODE = 3'h7;
   // toggle pulse lengths in ms, indexed by code
   localparam int PULSE_MS [8] =
      '{125, 250, 350, 500, 750, 1000, 1500, 2000};
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int NS_PER_MS = 1000000;
   localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam logic ENABLE_ASSERTED = 1'b1;
   localparam int PULSE_CNT_W = 32;
endpackage

// *** rtl/cge_reg_if.sv ***
`timescale 1ns/1ps
// register access from the serial port into the bank
interface cge_reg_if;
   logic wr_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport port (output wr_en, output addr, output wdata, input rdata);
   modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** rtl/cge_serial_port.sv ***
`timescale 1ns/1ps
// two-wire serial slave, oversampled on the system clock
module cge_serial_port
#(
   parameter logic [6:0] DEV_ADDR = 7'h35
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic sda_out,
   output logic sda_oe,
   cge_reg_if.port regs
);
   import cge_pkg::*;
   typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA,
      S_WDATA_ACK, S_RDATA, S_RDATA_ACK} cge_state_t;
   cge_state_t state_ff;
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_prev_ff;
   logic sda_prev_ff;
   logic [7:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] ptr_ff;
   logic read_ff;
   logic wr_en_ff;
   logic [7:0] wdata_ff;
   logic [7:0] wr_addr_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // two-stage pin synchronisers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end
      else
      begin
         scl_sync_ff <= {scl_sync_ff[0], scl_pin};
         sda_sync_ff <= {sda_sync_ff[0], sda_pin};
         scl_prev_ff <= scl_sync_ff[1];
         sda_prev_ff <= sda_sync_ff[1];
      end
   end

   // bus events
   assign scl_rise = scl_sync_ff[1] && !scl_prev_ff;
   assign scl_fall = !scl_sync_ff[1] && scl_prev_ff;
   assign start_seen = scl_sync_ff[1] && scl_prev_ff && sda_prev_ff &&
      !sda_sync_ff[1];
   assign stop_seen = scl_sync_ff[1] && scl_prev_ff && !sda_prev_ff &&
      sda_sync_ff[1];

   // transfer sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_ff <= S_IDLE;
         shift_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         ptr_ff <= 8'h00;
         read_ff <= 1'b0;
         sda_oe <= 1'b0;
         wr_en_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wr_addr_ff <= 8'h00;
      end
      else
      begin
         wr_en_ff <= 1'b0;
         if (start_seen)
         begin
            state_ff <= S_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe <= 1'b0;
         end
         else if (stop_seen)
         begin
            state_ff <= S_IDLE;
            sda_oe <= 1'b0;
         end
         else if (scl_rise)
         begin
            case (state_ff)
               S_ADDR, S_PTR, S_WDATA:
               begin
                  shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               S_RDATA:
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               S_RDATA_ACK:
                  if (sda_sync_ff[1])
                     state_ff <= S_IDLE; // master nack ends the read
               default:
                  state_ff <= state_ff;
            endcase
         end
         else if (scl_fall)
         begin
            case (state_ff)
               S_ADDR:
                  if (bit_cnt_ff == 4'h8)
                  begin
                     if (shift_ff[7:1] == DEV_ADDR)
                     begin
                        read_ff <= shift_ff[0];
                        sda_oe <= 1'b1;
                        state_ff <= S_ADDR_ACK;
                     end
                     else
                        state_ff <= S_IDLE;
                  end
               S_PTR, S_WDATA:
                  if (bit_cnt_ff == 4'h8)
                  begin
                     sda_oe <= 1'b1;
                     if (state_ff == S_PTR)
                     begin
                        ptr_ff <= shift_ff;
                        state_ff <= S_PTR_ACK;
                     end
                     else
                     begin
                        wr_en_ff <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wdata_ff <= shift_ff;
                        ptr_ff <= ptr_ff + 8'h01;
                        state_ff <= S_WDATA_ACK;
                     end
                  end
               S_ADDR_ACK, S_RDATA_ACK:
               begin
                  bit_cnt_ff <= 4'h0;
                  if (read_ff)
                  begin
                     shift_ff <= regs.rdata;
                     sda_oe <= !regs.rdata[7];
                     state_ff <= S_RDATA;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state_ff <= S_PTR;
                  end
               end
               S_PTR_ACK, S_WDATA_ACK:
               begin
                  sda_oe <= 1'b0;
                  bit_cnt_ff <= 4'h0;
                  state_ff <= S_WDATA;
               end
               S_RDATA:
                  if (bit_cnt_ff == 4'h8)
                  begin
                     sda_oe <= 1'b0;
                     ptr_ff <= ptr_ff + 8'h01;
                     state_ff <= S_RDATA_ACK;
                  end
                  else
                  begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     sda_oe <= !shift_ff[6];
                  end
               default:
                  state_ff <= state_ff;
            endcase
         end
      end
   end

   // open-drain pin only ever pulls low, kept in a flop like every pin
   always_ff @(posedge sys_clk)
      sda_out <= 1'b0;

   // register side of the port
   assign regs.wr_en = wr_en_ff;
   assign regs.addr = wr_en_ff ? wr_addr_ff : ptr_ff;
   assign regs.wdata = wdata_ff;
endmodule

// *** rtl/cge_ctrl_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// [RL1] address 0x00 reads a fixed id byte: version high nibble, revision low.
// [RL2] bit 7 at 0x02 set puts everything but the serial port to sleep; ACTIVE_MODE still follows 0x03 and code 00 keeps the enable output on.
// [RL3] bit 1 at 0x02 set suppresses downstream charging-port signalling.
// [RL4] bits 7:6 at 0x03 drive the enable output: 00 on, 10 off, 11 mode.
// [RL5] bits 5:3 at 0x03 pick the toggle pulse length from 125 ms to 2 s.
// [RL6] bits 2:0 at 0x03 pick one of eight operating modes.
// [RL7] host software keeps factory and reserved bits at power-on values.
// [RL8] reset loads 0xA7 at 0x01 and 0xE9 at 0x03.
// [RL9] shorted charger mode powers the bus and shorts the data lines.
// [RL10] pass-through mode connects host data lines straight through.
// [RL11] writes to the id byte are ignored and it always reads fixed.
module cge_ctrl_regs
   import cge_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h35,
   parameter logic [3:0] VERSION_CODE = 4'h3, // arbitrary value
   parameter logic [3:0] SILICON_REVISION_CODE = 4'h2, // arbitrary value
   parameter int CYC_PER_MS = CYCLES_PER_MS
)
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic LIMIT_SWITCH_ENABLE_OUT,
   output logic SLEEP_ALL_BUT_HOST_PORT,
   output logic HOST_PATH_CONNECT,
   output logic DATA_LINE_SHORT,
   output logic DIVIDER_EN,
   output logic BUS_POWER_EN,
   output logic PORT_EMULATION_EN,
   output logic [2:0] ACTIVE_MODE
);
   import cge_pkg::*;
   cge_reg_if regs ();
   logic [7:0] factory_one_ff;
   logic [7:0] power_sig_ff;
   logic [7:0] enable_mode_ff;
   logic [7:0] reserved_four_ff;
   logic [PULSE_CNT_W-1:0] pulse_cnt_ff;
   logic [PULSE_CNT_W-1:0] pulse_len [8];
   logic sleep;
   logic [1:0] out_ctrl;
   logic [2:0] mode;
   logic [2:0] new_mode;
   logic mode_write;
   logic pulse_active;
   logic [7:0] rdata;
   logic nxt_enable;

   cge_serial_port #(.DEV_ADDR(DEV_ADDR)) u_port (
      .sys_clk(SYS_CLK),
      .rst_b(RST_B),
      .scl_pin(SCL),
      .sda_pin(SDA_IN),
      .sda_out(SDA_OUT),
      .sda_oe(SDA_OE),
      .regs(regs.port)
   );

   // pulse lengths in clock cycles per code
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_len
         assign pulse_len[gi] = PULSE_CNT_W'(PULSE_MS[gi] * CYC_PER_MS); // [RL5]
      end
   endgenerate

   // register writes; id byte has no storage
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         factory_one_ff <= RST_FACTORY_ONE; // [RL8]
         power_sig_ff <= RST_POWER_SIG;
         enable_mode_ff <= RST_ENABLE_MODE; // [RL8]
         reserved_four_ff <= RST_RESERVED_FOUR;
      end
      else if (regs.wr_en)
      begin
         case (regs.addr)
            ADDR_FACTORY_ONE: factory_one_ff <= regs.wdata; // [RL7]
            ADDR_POWER_SIG: power_sig_ff <= regs.wdata;
            ADDR_ENABLE_MODE: enable_mode_ff <= regs.wdata;
            ADDR_RESERVED_FOUR: reserved_four_ff <= regs.wdata;
            default: factory_one_ff <= factory_one_ff; // [RL11]
         endcase
      end
   end

   // read mux
   always_comb
   begin
      case (regs.addr)
         ADDR_IDENT: rdata = {VERSION_CODE, SILICON_REVISION_CODE}; // [RL1]
         ADDR_FACTORY_ONE: rdata = factory_one_ff;
         ADDR_POWER_SIG: rdata = power_sig_ff;
         ADDR_ENABLE_MODE: rdata = enable_mode_ff;
         ADDR_RESERVED_FOUR: rdata = reserved_four_ff;
         default: rdata = RD_UNMAPPED;
      endcase
   end
   assign regs.rdata = rdata;

   // field decode
   assign sleep = power_sig_ff[SLEEP_BIT]; // [RL2]
   assign out_ctrl = enable_mode_ff[CTRL_HI:CTRL_LO];
   assign mode = enable_mode_ff[MODE_HI:MODE_LO]; // [RL6]
   assign new_mode = regs.wdata[MODE_HI:MODE_LO];
   assign mode_write = regs.wr_en && regs.addr == ADDR_ENABLE_MODE &&
      new_mode != mode;
   assign pulse_active = pulse_cnt_ff != '0;

   // toggle pulse on a mode change outside the autodetect modes
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         pulse_cnt_ff <= '0;
      else if (sleep)
         pulse_cnt_ff <= '0; // [RL2]
      else if (mode_write && new_mode != autodetect_2a_mode &&
         new_mode != autodetect_1a_mode)
         pulse_cnt_ff <= pulse_len[regs.wdata[PULSE_HI:PULSE_LO]]; // [RL5]
      else if (pulse_active)
         pulse_cnt_ff <= pulse_cnt_ff - PULSE_CNT_W'(1);
   end

   // enable output selection
   always_comb
   begin
      case (out_ctrl)
         CTRL_ASSERT: nxt_enable = ENABLE_ASSERTED; // [RL4]
         CTRL_DEASSERT: nxt_enable = !ENABLE_ASSERTED; // [RL4]
         CTRL_BY_MODE: nxt_enable = pulse_active ? ENABLE_ASSERTED :
            !ENABLE_ASSERTED; // [RL4]
         default: nxt_enable = !ENABLE_ASSERTED;
      endcase
   end

   // registered mode outputs; all but ACTIVE_MODE, the sleep flag and the enable output held off while asleep
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         LIMIT_SWITCH_ENABLE_OUT <= !ENABLE_ASSERTED;
         SLEEP_ALL_BUT_HOST_PORT <= 1'b0;
         HOST_PATH_CONNECT <= 1'b0;
         DATA_LINE_SHORT <= 1'b0;
         DIVIDER_EN <= 1'b0;
         BUS_POWER_EN <= 1'b0;
         PORT_EMULATION_EN <= 1'b0;
         ACTIVE_MODE <= 3'h0;
      end
      else
      begin
         LIMIT_SWITCH_ENABLE_OUT <= nxt_enable;
         SLEEP_ALL_BUT_HOST_PORT <= sleep; // [RL2]
         ACTIVE_MODE <= mode; // [RL6]
         HOST_PATH_CONNECT <= !sleep && (mode == pass_through_mode ||
            mode == downstream_port_emulation_mode); // [RL10]
         DATA_LINE_SHORT <= !sleep && (mode == shorted_charger_mode ||
            mode == FORCED_TABLET_MODE); // [RL9]
         DIVIDER_EN <= !sleep && mode != pass_through_mode &&
            mode != downstream_port_emulation_mode &&
            mode != shorted_charger_mode; // [RL9]
         BUS_POWER_EN <= !sleep && (mode == shorted_charger_mode ||
            mode == forced_1a_divider_mode ||
            mode == forced_2a_divider_mode ||
            mode == FORCED_TABLET_MODE); // [RL9]
         PORT_EMULATION_EN <= !sleep &&
            mode == downstream_port_emulation_mode &&
            !power_sig_ff[SIG_DISABLE_BIT]; // [RL3]
      end
   end
endmodule

// *** tb/cge_ctrl_regs_assertions.sv ***
`timescale 1ns/1ps
// pin-level checks on the control bank
module cge_ctrl_regs_assertions
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic SCL,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic LIMIT_SWITCH_ENABLE_OUT,
   input wire logic SLEEP_ALL_BUT_HOST_PORT,
   input wire logic HOST_PATH_CONNECT,
   input wire logic DATA_LINE_SHORT,
   input wire logic DIVIDER_EN,
   input wire logic BUS_POWER_EN,
   input wire logic PORT_EMULATION_EN,
   input wire logic [2:0] ACTIVE_MODE
);
   logic [1:0] age_ff;
   logic [2:0] last_mode_ff;
   logic last_sleep_ff;
   logic steady;
   logic awake;
   // cycles since reset release, saturating
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         age_ff <= 2'h0;
      else if (age_ff != 2'h3)
         age_ff <= age_ff + 2'h1;
   end
   // previous mode and sleep, for settle detection
   always_ff @(posedge SYS_CLK)
   begin
      last_mode_ff <= ACTIVE_MODE;
      last_sleep_ff <= SLEEP_ALL_BUT_HOST_PORT;
   end
   // outputs judged once the fields stopped moving, except by the two reset checks
   assign steady = age_ff == 2'h3 && last_mode_ff == ACTIVE_MODE
      && last_sleep_ff == SLEEP_ALL_BUT_HOST_PORT;
   assign awake = steady && !SLEEP_ALL_BUT_HOST_PORT;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   property p_host_path;
      awake |-> HOST_PATH_CONNECT == (ACTIVE_MODE inside {3'h1, 3'h3});
   endproperty
   a_host_path: assert property (p_host_path)
      else $error("host path wrong for mode");
   property p_short;
      awake && ACTIVE_MODE == 3'h2 |-> DATA_LINE_SHORT && BUS_POWER_EN
         && !DIVIDER_EN;
   endproperty
   a_short: assert property (p_short)
      else $error("shorted charger outputs wrong");
   property p_divider;
      awake |-> DIVIDER_EN == !(ACTIVE_MODE inside {3'h1, 3'h2, 3'h3});
   endproperty
   a_divider: assert property (p_divider)
      else $error("divider enable wrong for mode");
   property p_bus_power;
      awake |-> BUS_POWER_EN == (ACTIVE_MODE inside {3'h2, [3'h5:3'h7]});
   endproperty
   a_bus_power: assert property (p_bus_power)
      else $error("bus power wrong for mode");
   property p_sleep_quiet;
      steady && SLEEP_ALL_BUT_HOST_PORT |-> !(HOST_PATH_CONNECT
         || DATA_LINE_SHORT || DIVIDER_EN || BUS_POWER_EN
         || PORT_EMULATION_EN);
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("mode outputs active while asleep");
   property p_emulation;
      awake && ACTIVE_MODE != 3'h3 |-> !PORT_EMULATION_EN;
   endproperty
   a_emulation: assert property (p_emulation)
      else $error("port emulation outside its mode");
   property p_reset_quiet;
      $rose(RST_B) |-> !SDA_OE && !LIMIT_SWITCH_ENABLE_OUT
         && !SLEEP_ALL_BUT_HOST_PORT && ACTIVE_MODE == 3'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");
   property p_reset_mode;
      $rose(RST_B) |-> ##[1:2] (HOST_PATH_CONNECT && ACTIVE_MODE == 3'h1);
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("pass-through not selected after reset");
endmodule

bind cge_ctrl_regs cge_ctrl_regs_assertions i_chk
(
   .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCL(SCL), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .LIMIT_SWITCH_ENABLE_OUT(LIMIT_SWITCH_ENABLE_OUT),
   .SLEEP_ALL_BUT_HOST_PORT(SLEEP_ALL_BUT_HOST_PORT),
   .HOST_PATH_CONNECT(HOST_PATH_CONNECT), .DATA_LINE_SHORT(DATA_LINE_SHORT),
   .DIVIDER_EN(DIVIDER_EN), .BUS_POWER_EN(BUS_POWER_EN),
   .PORT_EMULATION_EN(PORT_EMULATION_EN), .ACTIVE_MODE(ACTIVE_MODE)
);

// *** tb/charger_emulator_ctrl_regs_tb.sv ***
`timescale 1ns/1ps
// drives the bank over the two-wire port and checks it
module charger_emulator_ctrl_regs_tb;
   import cge_pkg::*;
   localparam logic [6:0] DEV = 7'h35;
   localparam logic [7:0] ID = 8'h32; // arbitrary id value
   logic sys_clk, rst_b, scl, sda_m, sda_oe, sda_out, lse, sleep;
   logic host, short_dl, div, bus, emu, k;
   logic [2:0] mode;
   logic [7:0] mdl [8];
   logic [7:0] q;
   int bad_count, compares, pcnt;
   int seed = 32'hc43b_7bc1;
   int pulse_ms [8] = '{125, 250, 350, 500, 750, 1000, 1500, 2000};
   wire sda = sda_m & !sda_oe; // pulled-up wire
   cge_ctrl_regs #(.DEV_ADDR(DEV), .VERSION_CODE(4'h3),
      .SILICON_REVISION_CODE(4'h2), .CYC_PER_MS(2)) i_dut
   (
      .SYS_CLK(sys_clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LIMIT_SWITCH_ENABLE_OUT(lse),
      .SLEEP_ALL_BUT_HOST_PORT(sleep), .HOST_PATH_CONNECT(host),
      .DATA_LINE_SHORT(short_dl), .DIVIDER_EN(div), .BUS_POWER_EN(bus),
      .PORT_EMULATION_EN(emu), .ACTIVE_MODE(mode)
   );
   // clock and enable-pulse length counter
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      if (lse === 1'b1) pcnt++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // one serial bit, level sampled late in the high phase
   task automatic sbit(input logic b, output logic r);
      sda_m = b;
      hold(8);
      scl = 1'b1;
      hold(8);
      r = sda;
      scl = 1'b0;
      hold(4);
   endtask
   task automatic start;
      sda_m = 1'b1;
      hold(4);
      scl = 1'b1;
      hold(8);
      sda_m = 1'b0;
      hold(8);
      scl = 1'b0;
      hold(4);
   endtask
   task automatic stop;
      sda_m = 1'b0;
      hold(4);
      scl = 1'b1;
      hold(8);
      sda_m = 1'b1;
      hold(8);
   endtask
   task automatic sbyte(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
         sbit(d[i], r[i]);
      sbit(1'b1, k);
   endtask
   // register write, mirrored into the model
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start;
      sbyte({DEV, 1'b0}, r);
      sbyte(a, r);
      sbyte(d, r);
      check({6'h0, k, sda_out}, 8'h00);
      stop;
      if (a inside {[8'h01:8'h04]})
         mdl[a] = d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      logic [7:0] r;
      start;
      sbyte({DEV, 1'b0}, r);
      sbyte(a, r);
      start;
      sbyte({DEV, 1'b1}, r);
      sbyte(8'hFF, v);
      stop;
   endtask
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return a == 8'h00 ? ID : (a < 8'h05 ? mdl[a] : 8'h00);
   endfunction
   function automatic logic [4:0] exp_out(input int m);
      if (mdl[2][7])
         return 5'h00;
      return {m == 1 || m == 3, m == 2 || m == 7, !(m inside {1, 2, 3}),
         m inside {2, 5, 6, 7}, m == 3 && !mdl[2][1]};
   endfunction
   task automatic chk_out(input int m);
      check({5'h0, mode}, 8'(m));
      check({2'h0, sleep, host, short_dl, div, bus, emu},
         {2'h0, mdl[2][7], exp_out(m)});
   endtask
   // watchdog for a hung run
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish;
   end
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      scl = 1'b1;
      sda_m = 1'b1;
      pcnt = 0;
      mdl = '{8'h00, 8'hA7, 8'h50, 8'hE9, 8'h00, 8'h00, 8'h00, 8'h00};
      hold(16);
      rst_b = 1'b1;
      hold(4);
      chk_out(1);
      for (int a = 0; a < 6; a++)
      begin
         rd(8'(a), q);
         check(q, exp_rd(8'(a)));
      end
      repeat (3)
      begin
         wr(8'h00, 8'($random(seed)));
         rd(8'h00, q);
         check(q, ID);
      end
      wr(8'h01, 8'hA7);
      wr(8'h04, 8'h00);
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h03, {5'b00101, 3'(m)});
         chk_out(m);
         check({7'h0, lse}, 8'h01);
         rd(8'h03, q);
         check(q, exp_rd(8'h03));
      end
      wr(8'h03, 8'h8B);
      check({7'h0, lse}, 8'h00);
      wr(8'h03, 8'h4B);
      check({7'h0, lse}, 8'h00);
      chk_out(3);
      wr(8'h02, 8'h52);
      chk_out(3);
      wr(8'h02, 8'hD0);
      chk_out(3);
      rd(8'h02, q);
      check(q, exp_rd(8'h02));
      wr(8'h02, 8'h50);
      chk_out(3);
      for (int c = 0; c < 8; c++)
      begin
         pcnt = 0;
         wr(8'h03, {2'b11, 3'(c), c[0] ? 3'b101 : 3'b110});
         hold(pulse_ms[c] * 2 + 50);
         check(8'(pcnt), 8'(2 * pulse_ms[c]));
         check(8'(pcnt >> 8), 8'((2 * pulse_ms[c]) >> 8));
      end
      // no toggle pulse on a change into an autodetect mode
      pcnt = 0;
      wr(8'h03, 8'hC0);
      hold(300);
      check(8'(pcnt), 8'h00);
      chk_out(0);
      // reset in mid-run restores the power-on values
      rst_b = 1'b0;
      hold(4);
      rst_b = 1'b1;
      mdl = '{8'h00, 8'hA7, 8'h50, 8'hE9, 8'h00, 8'h00, 8'h00, 8'h00};
      hold(4);
      chk_out(1);
      for (int a = 1; a < 5; a++)
      begin
         rd(8'(a), q);
         check(q, exp_rd(8'(a)));
      end
      tally_and_finish;
   end
endmodule
